// ### acl_hdr_source.sv
// ingress parser stand-in: one header pulse per request
// assumes the bench raises go for one cycle per header
`timescale 1ns/1ns
module acl_hdr_source (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic go,
    input wire acl_pkg::hdr_t hdr_in,
    output logic hdr_valid,
    output acl_pkg::hdr_t hdr
);
    import acl_pkg::*;
    // fields toggle between pulses so nothing stale looks valid
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hdr_valid <= 1'b0;
            hdr <= '0;
        end
        else
        begin
            hdr_valid <= go;
            hdr <= go ? hdr_in : ~hdr;
        end
    end
endmodule : acl_hdr_source

// ### acl_match_rule_engine.sv
// acl match engine: rule table behind ahb-lite, header match, counters
// assumes one header per hdr_valid pulse from the ingress parser
`timescale 1ns/1ns
module acl_match_rule_engine (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic hdr_valid,
    input wire acl_pkg::hdr_t hdr,
    output logic res_valid,
    output acl_pkg::result_t res,
    output logic [15:0] count_event
);
    import acl_pkg::*;

    logic [31:0] ctrl_mem [NRULE];
    logic [31:0] a_mem [NRULE];
    logic [31:0] b_mem [NRULE];
    logic [31:0] flg_mem [NRULE];
    logic [31:0] act_mem [NRULE];
    logic [31:0] proc_mem [NRULE];
    logic [CNT_W-1:0] cnt_reg [NRULE];
    logic [15:0] armed_reg;
    logic [15:0] evt_reg;
    logic [15:0] status_reg;
    logic wr_pend_reg;
    logic [31:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic res_valid_reg;
    result_t res_reg;
    logic [7:0] us_cnt_reg;
    logic [9:0] ms_cnt_reg;
    logic us_tick_reg;
    logic ms_tick_reg;
    logic [15:0] match_vec;
    logic [15:0] qual_vec;
    logic [15:0] cnt_mode;
    logic [15:0] pe_hit;
    logic [15:0] act_hit;
    logic [3:0] sel_idx;
    logic sel_any;
    logic ahb_take;

    // evaluates one matching rule: {count qualifier, match result}
    function automatic logic [1:0] rule_eval(input logic [31:0] c,
        input logic [31:0] a, input logic [31:0] b, input logic [31:0] f,
        input hdr_t h);
        logic [1:0] ls;
        logic [1:0] cs;
        logic [1:0] pc;
        logic sd;
        logic pol;
        logic [47:0] mac;
        logic [15:0] port;
        logic [31:0] ip;
        logic l2_eq;
        logic port_ok;
        logic flag_ok;
        logic hit;
        logic qual;
        ls = c[CTRL_LS_LSB +: 2];
        cs = c[CTRL_CS_LSB +: 2];
        pc = c[CTRL_PC_LSB +: 2];
        sd = c[CTRL_SD_BIT];
        pol = c[CTRL_POL_BIT];
        mac = sd ? h.src_mac : h.dst_mac;
        port = sd ? h.src_port : h.dst_port;
        ip = sd ? h.src_ip : h.dst_ip;
        l2_eq = (mac == {b[15:0], a}) && (h.ether_type == b[31:16]);
        unique case (pc)
            PC_NONE: port_ok = 1'b1;
            PC_EITHER: port_ok = (port == a[31:16]) || (port == a[15:0]);
            PC_INSIDE: port_ok = (port >= a[15:0]) && (port <= a[31:16]);
            PC_OUTSIDE: port_ok = (port < a[15:0]) || (port > a[31:16]);
        endcase
        if (pc != PC_NONE)
        begin
            port_ok = (port_ok == pol);
        end
        flag_ok = !c[CTRL_FME_BIT] || (((h.tcp_flags
            ^ f[FLG_VAL_LSB +: 8]) & ~f[FLG_MASK_LSB +: 8]) == 8'h00);
        hit = 1'b0;
        qual = 1'b0;
        unique case (ls)
            LS_OFF: hit = 1'b0;
            LS_L2:
            begin
                unique case (cs)
                    CS_0: qual = (l2_eq == pol);
                    CS_1: hit = ((h.ether_type == b[31:16]) == pol);
                    CS_2: hit = ((mac == {b[15:0], a}) == pol);
                    CS_3: hit = (l2_eq == pol);
                endcase
            end
            LS_L3:
            begin
                unique case (cs)
                    CS_1: hit = h.is_ipv4
                        && ((((ip ^ a) & ~b) == 32'h00000000) == pol);
                    CS_2: hit = h.is_ipv4 && (((h.src_ip == a)
                        && (h.dst_ip == b)) == pol);
                    default: hit = 1'b0;
                endcase
            end
            LS_L4:
            begin
                unique case (cs)
                    CS_0: hit = h.is_ipv4
                        && ((h.ip_proto == c[CTRL_PRO_LSB +: 8]) == pol);
                    CS_1: hit = h.is_tcp && port_ok && flag_ok;
                    CS_2: hit = h.is_udp && port_ok;
                    CS_3: hit = h.is_tcp && ((h.tcp_seq == a) == pol)
                        && flag_ok;
                endcase
            end
        endcase
        return {qual, hit};
    endfunction : rule_eval

    // read value of one table or status word
    function automatic logic [31:0] read_word(input logic [31:0] addr);
        logic [3:0] e;
        logic [31:0] v;
        e = addr[TBL_ENTRY_LSB +: 4];
        v = RESET_WORD;
        if (addr == STATUS_ADDR)
        begin
            v = {16'h0000, status_reg};
        end
        else if (addr < TBL_SPAN)
        begin
            unique case (addr[TBL_WORD_LSB +: 3])
                W_CTRL: v = ctrl_mem[e];
                W_DATA_A: v = a_mem[e];
                W_DATA_B: v = b_mem[e];
                W_FLAGS: v = flg_mem[e];
                W_ACTION: v = act_mem[e];
                W_PROC: v = proc_mem[e];
                W_COUNT: v = {21'h0, cnt_reg[e]};
                default: v = RESET_WORD;
            endcase
        end
        return v;
    endfunction : read_word

    // per-rule evaluation and count-mode detection
    always_comb
    begin
        for (int i = 0; i < NRULE; i++)
        begin
            {qual_vec[i], match_vec[i]} = rule_eval(ctrl_mem[i], a_mem[i],
                b_mem[i], flg_mem[i], hdr);
            cnt_mode[i] = (ctrl_mem[i][CTRL_LS_LSB +: 2] == LS_L2)
                && (ctrl_mem[i][CTRL_CS_LSB +: 2] == CS_0);
        end
    end

    // processing entries: AND inside a group, OR per action pointer
    always_comb
    begin
        act_hit = 16'h0000;
        for (int p = 0; p < NRULE; p++)
        begin
            pe_hit[p] = hdr_valid
                && (proc_mem[p][PROC_MASK_LSB +: 16] != 16'h0000)
                && ((match_vec & proc_mem[p][PROC_MASK_LSB +: 16])
                == proc_mem[p][PROC_MASK_LSB +: 16]);
            if (pe_hit[p] && !cnt_mode[proc_mem[p][PROC_PTR_LSB +: 4]])
            begin
                act_hit[proc_mem[p][PROC_PTR_LSB +: 4]] = 1'b1;
            end
        end
    end

    // lowest-numbered hit action wins
    always_comb
    begin
        sel_idx = 4'h0;
        sel_any = 1'b0;
        for (int i = NRULE - 1; i >= 0; i--)
        begin
            if (act_hit[i])
            begin
                sel_idx = 4'(i);
                sel_any = 1'b1;
            end
        end
    end

    // verdict register, one cycle after the header
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            res_valid_reg <= 1'b0;
            res_reg <= '0;
        end
        else
        begin
            res_valid_reg <= hdr_valid;
            if (hdr_valid)
            begin
                res_reg.hit <= sel_any;
                res_reg.index <= sel_idx;
                res_reg.action <= act_mem[sel_idx][CNT_W-1:0];
            end
        end
    end

    // microsecond and millisecond ticks
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            us_cnt_reg <= 8'h00;
            ms_cnt_reg <= 10'h000;
            us_tick_reg <= 1'b0;
            ms_tick_reg <= 1'b0;
        end
        else
        begin
            us_tick_reg <= (us_cnt_reg == 8'(US_CYCLES - 1));
            us_cnt_reg <= (us_cnt_reg == 8'(US_CYCLES - 1)) ? 8'h00
                : us_cnt_reg + 8'h01;
            ms_tick_reg <= us_tick_reg && (ms_cnt_reg == 10'(MS_US - 1));
            if (us_tick_reg)
            begin
                ms_cnt_reg <= (ms_cnt_reg == 10'(MS_US - 1)) ? 10'h000
                    : ms_cnt_reg + 10'h001;
            end
        end
    end

    // count-mode counters: watchdog or event counting
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NRULE; i++)
            begin
                cnt_reg[i] <= '0;
            end
            armed_reg <= 16'h0000;
            evt_reg <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < NRULE; i++)
            begin
                evt_reg[i] <= 1'b0;
                if (!cnt_mode[i])
                begin
                    cnt_reg[i] <= '0;
                    armed_reg[i] <= 1'b0;
                end
                else if (act_mem[i][ACT_CA_BIT])
                begin
                    armed_reg[i] <= 1'b0;
                    if (hdr_valid && qual_vec[i])
                    begin
                        if (cnt_reg[i] + 11'h001 >= act_mem[i][CNT_W-1:0])
                        begin
                            evt_reg[i] <= 1'b1;
                            cnt_reg[i] <= '0;
                        end
                        else
                        begin
                            cnt_reg[i] <= cnt_reg[i] + 11'h001;
                        end
                    end
                end
                else if (hdr_valid && qual_vec[i])
                begin
                    cnt_reg[i] <= act_mem[i][CNT_W-1:0];
                    armed_reg[i] <= 1'b1;
                end
                else if (armed_reg[i] && (act_mem[i][ACT_TU_BIT]
                    ? ms_tick_reg : us_tick_reg))
                begin
                    if (cnt_reg[i] <= 11'h001)
                    begin
                        evt_reg[i] <= 1'b1;
                        armed_reg[i] <= 1'b0;
                        cnt_reg[i] <= '0;
                    end
                    else
                    begin
                        cnt_reg[i] <= cnt_reg[i] - 11'h001;
                    end
                end
            end
        end
    end

    assign ahb_take = hsel && hready && htrans[1];

    // ahb address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h00000000;
            hrdata_reg <= 32'h00000000;
        end
        else
        begin
            wr_pend_reg <= ahb_take && hwrite;
            if (ahb_take)
            begin
                wr_addr_reg <= haddr;
            end
            if (ahb_take && !hwrite)
            begin
                // forward a write still in its data phase
                if (wr_pend_reg && (wr_addr_reg == haddr)
                    && (haddr < TBL_SPAN)
                    && (haddr[TBL_WORD_LSB +: 3] < W_COUNT))
                begin
                    // only writable words forward, masked as they are stored
                    hrdata_reg <= hwdata & (haddr[TBL_WORD_LSB +: 3]
                        == W_CTRL ? CTRL_WMASK : haddr[TBL_WORD_LSB +: 3]
                        == W_FLAGS ? FLAGS_WMASK : haddr[TBL_WORD_LSB +: 3]
                        == W_ACTION ? ACTION_WMASK : haddr[TBL_WORD_LSB +: 3]
                        == W_PROC ? PROC_WMASK : 32'hFFFFFFFF);
                end
                else
                begin
                    hrdata_reg <= read_word(haddr);
                end
            end
        end
    end

    // table writes in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NRULE; i++)
            begin
                ctrl_mem[i] <= RESET_WORD;
                a_mem[i] <= RESET_WORD;
                b_mem[i] <= RESET_WORD;
                flg_mem[i] <= RESET_WORD;
                act_mem[i] <= RESET_WORD;
                proc_mem[i] <= RESET_WORD;
            end
        end
        else if (wr_pend_reg && (wr_addr_reg < TBL_SPAN))
        begin
            unique case (wr_addr_reg[TBL_WORD_LSB +: 3])
                W_CTRL: ctrl_mem[wr_addr_reg[TBL_ENTRY_LSB +: 4]]
                    <= hwdata & CTRL_WMASK;
                W_DATA_A: a_mem[wr_addr_reg[TBL_ENTRY_LSB +: 4]] <= hwdata;
                W_DATA_B: b_mem[wr_addr_reg[TBL_ENTRY_LSB +: 4]] <= hwdata;
                W_FLAGS: flg_mem[wr_addr_reg[TBL_ENTRY_LSB +: 4]]
                    <= hwdata & FLAGS_WMASK;
                W_ACTION: act_mem[wr_addr_reg[TBL_ENTRY_LSB +: 4]]
                    <= hwdata & ACTION_WMASK;
                W_PROC: proc_mem[wr_addr_reg[TBL_ENTRY_LSB +: 4]]
                    <= hwdata & PROC_WMASK;
                default: ;
            endcase
        end
    end

    // sticky count events, write one to clear, a new event wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status_reg <= 16'h0000;
        end
        else if (wr_pend_reg && (wr_addr_reg == STATUS_ADDR))
        begin
            status_reg <= (status_reg & ~hwdata[15:0]) | evt_reg;
        end
        else
        begin
            status_reg <= status_reg | evt_reg;
        end
    end

    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay
    assign hrdata = hrdata_reg;
    assign res_valid = res_valid_reg;
    assign res = res_reg;
    assign count_event = status_reg;

    localparam int UsCyc = US_CYCLES;

    sequence s_l2_type_eq;
        hdr_valid && (ctrl_mem[0][3:0] == 4'h5) && ctrl_mem[0][CTRL_POL_BIT]
            && (hdr.ether_type == b_mem[0][31:16]);
    endsequence

    sequence s_wd_expire;
        cnt_mode[7] && armed_reg[7] && !act_mem[7][ACT_CA_BIT]
            && !act_mem[7][ACT_TU_BIT] && (cnt_reg[7] == 11'h001)
            && us_tick_reg && !(hdr_valid && qual_vec[7]);
    endsequence

    property p_disabled;
        @(posedge hclk) disable iff (!hresetn)
            ((ctrl_mem[0][1:0] == LS_OFF) ? match_vec[0] : 1'b0) == 1'b0;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled rule matched");

    property p_lowest;
        @(posedge hclk) disable iff (!hresetn)
            (hdr_valid && act_hit[0]) |=> (res.hit && res.index == 4'h0);
    endproperty
    a_lowest: assert property (p_lowest)
        else $error("action zero hit but not chosen");

    property p_group_and;
        @(posedge hclk) disable iff (!hresetn)
            (hdr_valid && proc_mem[0][15:0] != 16'h0000
            && (match_vec & proc_mem[0][15:0]) != proc_mem[0][15:0])
            |-> !pe_hit[0];
    endproperty
    a_group_and: assert property (p_group_and)
        else $error("entry hit with a selected rule false");

    property p_or_share;
        @(posedge hclk) disable iff (!hresetn)
            (pe_hit[4] && !cnt_mode[proc_mem[4][19:16]])
            |=> res.hit && (res.index <= $past(proc_mem[4][19:16]));
    endproperty
    a_or_share: assert property (p_or_share)
        else $error("hitting entry gave no action");

    property p_polarity;
        @(posedge hclk) disable iff (!hresetn)
            s_l2_type_eq |-> match_vec[0];
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("equal ethertype did not match");

    property p_watchdog;
        @(posedge hclk) disable iff (!hresetn)
            s_wd_expire |=> evt_reg[7] ##1 status_reg[7];
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog expiry not flagged");

    property p_event_cnt;
        @(posedge hclk) disable iff (!hresetn)
            (cnt_mode[6] && act_mem[6][ACT_CA_BIT] && hdr_valid && qual_vec[6]
            && cnt_reg[6] + 11'h001 >= act_mem[6][10:0])
            |=> evt_reg[6] && cnt_reg[6] == 11'h000;
    endproperty
    a_event_cnt: assert property (p_event_cnt)
        else $error("terminal count not flagged");

    property p_us_tick;
        @(posedge hclk) disable iff (!hresetn)
            us_tick_reg |-> ##UsCyc us_tick_reg;
    endproperty
    a_us_tick: assert property (p_us_tick)
        else $error("microsecond tick spacing wrong");

    property p_sticky;
        @(posedge hclk) disable iff (!hresetn)
            evt_reg[7] |=> status_reg[7];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("event lost by status clear");
endmodule : acl_match_rule_engine

// ### acl_match_rule_engine_tb.sv
// bench of the acl match engine: table rows, priority, counters
// assumes acl_pkg and acl_hdr_source are compiled first
`timescale 1ns/1ns
module acl_match_rule_engine_tb;
    import acl_pkg::*;
    typedef struct packed {
        logic [31:0] c;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] f;
        logic e;
    } row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic go = 1'b0;
    logic hready, hreadyout, hresp, hdr_valid, res_valid;
    logic [31:0] hrdata, q;
    logic [15:0] count_event;
    hdr_t h0, hdr;
    result_t res;
    int err_count = 0;
    int checks = 0;
    int cyc = 0;
    // entry 0 settings and whether the base header should hit
    row_t rows [20] = '{
        '{32'h24, 32'h0, 32'h8000000, 32'h0, 1'b0},
        '{32'h25, 32'h0, 32'h8000000, 32'h0, 1'b1},
        '{32'h29, 32'hA3A4A5A6, 32'hA1A2, 32'h0, 1'b1},
        '{32'h39, 32'hB3B4B5B6, 32'hB1B2, 32'h0, 1'b1},
        '{32'h2D, 32'hA3A4A5A6, 32'h801A1A2, 32'h0, 1'b0},
        '{32'h05, 32'h0, 32'h8010000, 32'h0, 1'b1},
        '{32'h26, 32'hC0A800FF, 32'hFF, 32'h0, 1'b1},
        '{32'h26, 32'hC0A800FF, 32'h0, 32'h0, 1'b0},
        '{32'h2A, 32'hA000001, 32'hC0A80001, 32'h0, 1'b1},
        '{32'h22, 32'hA000001, 32'hC0A80001, 32'h0, 1'b0},
        '{32'h2E, 32'hA000001, 32'hC0A80001, 32'h0, 1'b0},
        '{32'h60023, 32'h0, 32'h0, 32'h0, 1'b1},
        '{32'hA7, 32'h1F951F00, 32'h0, 32'h0, 1'b1},
        '{32'hE7, 32'h1F951F00, 32'h0, 32'h0, 1'b0},
        '{32'hC7, 32'h1F951F00, 32'h0, 32'h0, 1'b1},
        '{32'h77, 32'h501234, 32'h0, 32'h0, 1'b1},
        '{32'h6B, 32'h1F901F90, 32'h0, 32'h0, 1'b0},
        '{32'h2F, 32'h12345678, 32'h0, 32'h0, 1'b1},
        '{32'h127, 32'h0, 32'h0, 32'h1002, 1'b1},
        '{32'h127, 32'h0, 32'h0, 32'h2, 1'b0}};

    assign hready = hreadyout;
    always #2 hclk = ~hclk;

    acl_match_rule_engine uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .hdr_valid(hdr_valid),
        .hdr(hdr), .res_valid(res_valid), .res(res),
        .count_event(count_event));
    acl_hdr_source src (
        .hclk(hclk), .hresetn(hresetn), .go(go), .hdr_in(h0),
        .hdr_valid(hdr_valid), .hdr(hdr));

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : wt

    // one single ahb-lite word transfer, read data left in q
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        chk("hresp", 32'(hresp), 32'h0);
        chk("hreadyout", 32'(hreadyout), 32'h1);
    endtask : xfer

    task automatic wr(input logic [3:0] e, input logic [2:0] w,
        input logic [31:0] d);
        xfer(1'b1, {23'h0, e, w, 2'h0}, d);
    endtask : wr

    // one header; verdict one cycle later, pulse lasts one cycle
    task automatic send(input logic hit, input logic [14:0] ia);
        @(posedge hclk);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        wt(1);
        chk("res_valid", 32'(res_valid), 32'h1);
        chk("hit", 32'(res.hit), 32'(hit));
        if (hit)
            chk("action", 32'({res.index, res.action}), 32'(ia));
        wt(1);
        chk("res_valid_end", 32'(res_valid), 32'h0);
    endtask : send

    task automatic rst();
        @(posedge hclk);
        hresetn <= 1'b0;
        wt(1);
        chk("rst_valid", 32'(res_valid), 32'h0);
        chk("rst_event", 32'(count_event), 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
    endtask : rst

    // cut a hang short
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            err_count++;
            print_verdict();
        end
    end

    initial
    begin
        h0 = '{48'hA1A2A3A4A5A6, 48'hB1B2B3B4B5B6, 16'h0800, 1'b1,
            1'b1, 1'b0, 32'hA000001, 32'hC0A80001, 8'h06, 16'h0050,
            16'h1F90, 32'h12345678, 8'h12};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // reset value, writable bits, unmapped read
        xfer(1'b0, 32'h0, 32'h0);
        chk("ctrl_reset", q, RESET_WORD);
        wr(4'h0, W_CTRL, 32'hFFFFFFFF);
        xfer(1'b0, 32'h0, 32'h0);
        chk("ctrl_mask", q, CTRL_WMASK);
        xfer(1'b0, 32'h204, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test registers done");
        wr(4'h0, W_ACTION, 32'h5A3);
        wr(4'h0, W_PROC, 32'h1);
        foreach (rows[i])
        begin
            wr(4'h0, W_CTRL, rows[i].c);
            wr(4'h0, W_DATA_A, rows[i].a);
            wr(4'h0, W_DATA_B, rows[i].b);
            wr(4'h0, W_FLAGS, rows[i].f);
            send(rows[i].e, 15'h05A3);
        end
        $display("test rows done");
        // rules 1 and 3 true, rule 2 disabled
        rst();
        for (int e = 1; e < 4; e += 2)
        begin
            wr(4'(e), W_CTRL, 32'h25);
            wr(4'(e), W_DATA_B, 32'h8000000);
        end
        wr(4'h1, W_PROC, 32'h70006);
        wr(4'h2, W_PROC, 32'h90008);
        wr(4'h3, W_PROC, 32'h5000A);
        wr(4'h5, W_ACTION, 32'h111);
        wr(4'h9, W_ACTION, 32'h222);
        send(1'b1, 15'h2911);
        wr(4'h3, W_PROC, 32'h50004);
        send(1'b1, 15'h4A22);
        wr(4'h4, W_PROC, 32'h50002);
        send(1'b1, 15'h2911);
        $display("test priority done");
        // event counter on 6, microsecond and millisecond watchdogs
        rst();
        for (int e = 6; e < 9; e++)
        begin
            wr(4'(e), W_CTRL, 32'h21);
            wr(4'(e), W_DATA_A, 32'hA3A4A5A6);
            wr(4'(e), W_DATA_B, 32'h800A1A2);
        end
        wr(4'h6, W_ACTION, 32'h1003);
        wr(4'h7, W_ACTION, 32'h2);
        wr(4'h8, W_ACTION, 32'h801);
        // a true plain rule pointing at a count-mode action entry
        wr(4'h0, W_CTRL, 32'h25);
        wr(4'h0, W_DATA_B, 32'h8000000);
        wr(4'h0, W_PROC, 32'h60001);
        send(1'b0, 15'h0);
        send(1'b0, 15'h0);
        wt(3);
        chk("event_early", 32'(count_event[6]), 32'h0);
        send(1'b0, 15'h0);
        wt(3);
        chk("event_term", 32'(count_event[6]), 32'h1);
        xfer(1'b1, STATUS_ADDR, 32'h40);
        wt(2);
        chk("event_clear", 32'(count_event[6]), 32'h0);
        wt(200);
        chk("dog_early", 32'(count_event[7]), 32'h0);
        wt(330);
        xfer(1'b0, STATUS_ADDR, 32'h0);
        chk("dog_status", q, 32'h80);
        $display("test counters done");
        print_verdict();
    end
endmodule : acl_match_rule_engine_tb

// ### acl_pkg.sv
// constants, field layout and carrier types of the acl match engine
// assumes a single 250 MHz core clock and word-wide ahb-lite access
package acl_pkg;
    localparam int NRULE = 16;
    localparam int CNT_W = 11;
    // register map: 16 entries of 8 words, then the status word
    localparam logic [31:0] TBL_SPAN = 32'h00000200;
    localparam logic [31:0] STATUS_ADDR = 32'h00000200;
    localparam int TBL_ENTRY_LSB = 5;
    localparam int TBL_WORD_LSB = 2;
    localparam logic [2:0] W_CTRL = 3'h0;
    localparam logic [2:0] W_DATA_A = 3'h1;
    localparam logic [2:0] W_DATA_B = 3'h2;
    localparam logic [2:0] W_FLAGS = 3'h3;
    localparam logic [2:0] W_ACTION = 3'h4;
    localparam logic [2:0] W_PROC = 3'h5;
    localparam logic [2:0] W_COUNT = 3'h6;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    // writable bits of each word, the rest read as zero
    localparam logic [31:0] CTRL_WMASK = 32'h00FF01FF;
    localparam logic [31:0] FLAGS_WMASK = 32'h0000FFFF;
    localparam logic [31:0] ACTION_WMASK = 32'h00001FFF;
    localparam logic [31:0] PROC_WMASK = 32'h000FFFFF;
    // control, flags, action and processing word fields
    localparam int CTRL_LS_LSB = 0;
    localparam int CTRL_CS_LSB = 2;
    localparam int CTRL_SD_BIT = 4;
    localparam int CTRL_POL_BIT = 5;
    localparam int CTRL_PC_LSB = 6;
    localparam int CTRL_FME_BIT = 8;
    localparam int CTRL_PRO_LSB = 16;
    localparam int FLG_VAL_LSB = 0;
    localparam int FLG_MASK_LSB = 8;
    localparam int ACT_TU_BIT = 11;
    localparam int ACT_CA_BIT = 12;
    localparam int PROC_MASK_LSB = 0;
    localparam int PROC_PTR_LSB = 16;
    // layer_select, compare_select and port_compare_mode codes
    localparam logic [1:0] LS_OFF = 2'h0;
    localparam logic [1:0] LS_L2 = 2'h1;
    localparam logic [1:0] LS_L3 = 2'h2;
    localparam logic [1:0] LS_L4 = 2'h3;
    localparam logic [1:0] CS_0 = 2'h0;
    localparam logic [1:0] CS_1 = 2'h1;
    localparam logic [1:0] CS_2 = 2'h2;
    localparam logic [1:0] CS_3 = 2'h3;
    localparam logic [1:0] PC_NONE = 2'h0;
    localparam logic [1:0] PC_EITHER = 2'h1;
    localparam logic [1:0] PC_INSIDE = 2'h2;
    localparam logic [1:0] PC_OUTSIDE = 2'h3;
    // count time base
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_US = 1000;

    // parsed ingress header fields
    typedef struct packed {
        logic [47:0] dst_mac;
        logic [47:0] src_mac;
        logic [15:0] ether_type;
        logic is_ipv4;
        logic is_tcp;
        logic is_udp;
        logic [31:0] src_ip;
        logic [31:0] dst_ip;
        logic [7:0] ip_proto;
        logic [15:0] src_port;
        logic [15:0] dst_port;
        logic [31:0] tcp_seq;
        logic [7:0] tcp_flags;
    } hdr_t;

    // verdict for one header
    typedef struct packed {
        logic hit;
        logic [3:0] index;
        logic [CNT_W-1:0] action;
    } result_t;
endpackage : acl_pkg
